// *** sbc_defines.vh ***
// constants of the initialisation and secured-mode configuration block
// Operation
// [RL1] io1 enable bit drives both io1 drivers
// [RL2] io0 enable bit drives both io0 drivers
// [RL3] cyclic sense: restore io0, off time drivers off
// [RL4] inversion set: opposite io0 driver during off time
// [RL5] misc register written only in init mode
// [RL6] random-code flag gates low-power entry
// [RL7] parity flag: check parity, else parity zero
// [RL8] interrupt pin pulses or holds low level
// [RL9] pulse width 100 us or 25 us
// [RL10] flash mode interrupt at half watchdog period
// [RL11] debug field 0xx off, 1xx selects safe mode
// [RL12] resistor mismatch sets debug flag
// [RL13] software debug code overrides hardware decode
// [RL14] valid secured write enters selected mode
// [RL15] master sends inverted random code
// [RL16] read command returns random code bits 5:0
// [RL17] return to init only from normal mode
// [RL18] safe pin low on partly inverted code in init
// [RL19] mismatched secured write is ignored
// [RL20] init-only writes outside init are discarded
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// ***********************************
// frame layout
// ***********************************
`define SBC_RW_READ       2'h0
`define SBC_RW_WRITE      2'h1
`define SBC_ADDR_IO       5'h07
`define SBC_ADDR_MISC     5'h08
`define SBC_ADDR_SPE      5'h09
`define SBC_FRAME_BITS    5'h10
`define SBC_HDR_LAST_BIT  5'h07
`define SBC_PARITY_BIT    8

// ***********************************
// register fields and reset values
// ***********************************
`define SBC_IO_CYC_INV    0
`define SBC_IO0_OUT_EN    1
`define SBC_IO1_OUT_EN    2
`define SBC_MISC_DBG_TOP  2
`define SBC_MISC_INT_FLSH 3
`define SBC_MISC_INT_WID  4
`define SBC_MISC_INT_LVL  5
`define SBC_MISC_PARITY   6
`define SBC_MISC_LP_RND   7
`define SBC_IO_RESET      8'h00
`define SBC_MISC_RESET    8'h00
`define SBC_SPE_RESET     8'h00
`define SBC_LFSR_SEED     6'h01

// ***********************************
// modes: select codes and device state
// ***********************************
`define SBC_SEL_RESET     2'h0
`define SBC_SEL_INIT      2'h1
`define SBC_SEL_FLASH     2'h2
`define SBC_MODE_RESET    2'h0
`define SBC_MODE_INIT     2'h1
`define SBC_MODE_FLASH    2'h2
`define SBC_MODE_NORMAL   2'h3

// ***********************************
// timing
// ***********************************
`define SBC_CLK_MHZ       200
`define SBC_INT_LONG_US   100
`define SBC_INT_SHORT_US  25
`define SBC_INT_LONG_CYC  15'h4E20 // 100 us at 200 MHz
`define SBC_INT_SHORT_CYC 15'h1388 // 25 us at 200 MHz

`endif

// *** sbc_spi_frame.v ***
// oversampled spi slave frame engine for the configuration block
`include "sbc_defines.vh"

module sbc_spi_frame (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire        sclk,
  input  wire        mosi,
  input  wire        cs_n,
  input  wire [7:0]  tx_byte,
  output reg         miso,
  output reg         hdr_valid,
  output reg  [7:0]  hdr_byte,
  output reg         frame_valid,
  output reg  [15:0] frame_word
);

  reg        sclk_m;
  reg        sclk_q;
  reg        sclk_d;
  reg        cs_m;
  reg        cs_q;
  reg        cs_d;
  reg        mosi_m;
  reg        mosi_q;
  reg [4:0]  bit_cnt;
  reg [15:0] shift_in;
  reg [7:0]  shift_out;

  wire sclk_rise = sclk_q & ~sclk_d;
  wire sclk_fall = ~sclk_q & sclk_d;
  wire cs_end    = cs_q & ~cs_d;

  // two-flop pin synchronisers, third stage only for edges
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_m <= 1'b0;
      sclk_q <= 1'b0;
      sclk_d <= 1'b0;
      cs_m   <= 1'b1;
      cs_q   <= 1'b1;
      cs_d   <= 1'b1;
      mosi_m <= 1'b0;
      mosi_q <= 1'b0;
    end else if (clk_en) begin
      sclk_m <= sclk;
      sclk_q <= sclk_m;
      sclk_d <= sclk_q;
      cs_m   <= cs_n;
      cs_q   <= cs_m;
      cs_d   <= cs_q;
      mosi_m <= mosi;
      mosi_q <= mosi_m;
    end
  end

  // shift in on rising, shift out on falling, msb first
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt     <= 5'h00;
      shift_in    <= 16'h0000;
      shift_out   <= 8'h00;
      miso        <= 1'b0;
      hdr_valid   <= 1'b0;
      hdr_byte    <= 8'h00;
      frame_valid <= 1'b0;
      frame_word  <= 16'h0000;
    end else if (clk_en) begin
      hdr_valid   <= 1'b0;
      frame_valid <= 1'b0;
      if (cs_end) begin
        frame_valid <= (bit_cnt == `SBC_FRAME_BITS);
        frame_word  <= shift_in;
      end
      if (cs_q) begin
        bit_cnt <= 5'h00;
        miso    <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_in <= {shift_in[14:0], mosi_q};
          if (bit_cnt != 5'h1F)
            bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `SBC_HDR_LAST_BIT) begin
            hdr_valid <= 1'b1;
            hdr_byte  <= {shift_in[6:0], mosi_q};
          end
        end
        if (sclk_fall) begin
          if (bit_cnt == 5'h08) begin
            shift_out <= tx_byte;
            miso      <= tx_byte[7];
          end else if (bit_cnt > 5'h08) begin
            miso      <= shift_out[6];
            shift_out <= {shift_out[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule // sbc_spi_frame

// *** sbc_init_mode_config.v ***
// initialisation registers, secured mode select, io and interrupt pin control
`include "sbc_defines.vh"

module sbc_init_mode_config #(
  parameter [14:0] INT_LONG_CYC  = `SBC_INT_LONG_CYC,
  parameter [14:0] INT_SHORT_CYC = `SBC_INT_SHORT_CYC
) (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       spi_sclk,
  input  wire       spi_mosi,
  input  wire       spi_cs_n,
  output wire       spi_miso,
  input  wire       mode_reset_done,
  input  wire       mode_normal_req,
  input  wire       lowpower,
  input  wire       cyc_active,
  input  wire       io0_hs_req,
  input  wire       io0_ls_req,
  input  wire       int_event,
  input  wire       int_clear,
  input  wire       wd_half_period,
  input  wire [1:0] dbg_hw_code,
  input  wire       dbg_flag_clear,
  output reg  [1:0] dev_mode,
  output reg        io1_drv_en,
  output reg        io0_hs_on,
  output reg        io0_ls_on,
  output reg        lowpower_random_entry,
  output reg        int_n,
  output reg        safe_n,
  output reg        dbg_mismatch,
  output reg        safe_override,
  output reg  [1:0] safe_mode_sel
);

  reg  [7:0]  io_pin_init_config;
  reg  [7:0]  misc_init_config;
  reg  [7:0]  secured_mode_register;
  reg  [5:0]  lfsr;
  reg  [5:0]  rnd_code;
  reg         code_armed;
  reg  [7:0]  tx_byte;
  reg         lp_d;
  reg         saved_hs;
  reg         saved_ls;
  reg  [14:0] int_cnt;
  reg  [1:0]  dbg_m;
  reg  [1:0]  dbg_q;
  wire        hdr_valid;
  wire [7:0]  hdr_byte;
  wire        frame_valid;
  wire [15:0] frame_word;

  // device mode state codes
  localparam [1:0] MD_RESET  = `SBC_MODE_RESET;
  localparam [1:0] MD_INIT   = `SBC_MODE_INIT;
  localparam [1:0] MD_FLASH  = `SBC_MODE_FLASH;
  localparam [1:0] MD_NORMAL = `SBC_MODE_NORMAL;

  // ***********************************
  // helpers
  // ***********************************
  function [5:0] lfsr_next;
    input [5:0] v;
    begin
      lfsr_next = {v[4:0], v[5] ^ v[4]};
    end
  endfunction

  // ***********************************
  // spi frame engine
  // ***********************************
  sbc_spi_frame u_spi (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .sclk        (spi_sclk),
    .mosi        (spi_mosi),
    .cs_n        (spi_cs_n),
    .tx_byte     (tx_byte),
    .miso        (spi_miso),
    .hdr_valid   (hdr_valid),
    .hdr_byte    (hdr_byte),
    .frame_valid (frame_valid),
    .frame_word  (frame_word)
  );

  // frame decode
  wire [1:0] f_rw    = frame_word[15:14];
  wire [4:0] f_addr  = frame_word[13:9];
  wire [7:0] f_data  = frame_word[7:0];
  wire       par_on  = misc_init_config[`SBC_MISC_PARITY];
  wire       par_ok  = par_on ? ~(^frame_word)                      // [RL7]
                              : ~frame_word[`SBC_PARITY_BIT];       // [RL7]
  wire       wr_ok   = frame_valid & (f_rw == `SBC_RW_WRITE) & par_ok;
  wire       in_init = (dev_mode == `SBC_MODE_INIT);
  wire       wr_io   = wr_ok & (f_addr == `SBC_ADDR_IO) & in_init;     // [RL20]
  wire       wr_misc = wr_ok & (f_addr == `SBC_ADDR_MISC) & in_init;   // [RL5] [RL20]
  wire       wr_spe  = wr_ok & (f_addr == `SBC_ADDR_SPE);
  wire [1:0] sel     = f_data[7:6];
  wire       c_inv   = code_armed & (f_data[5:0] == ~rnd_code);        // [RL15] [RL19]
  wire       c_safe  = code_armed &
                       (f_data[5:0] == {rnd_code[5:4], ~rnd_code[3:0]});
  wire       go_init = wr_spe & c_inv & (sel == `SBC_SEL_INIT) &
                       (dev_mode == `SBC_MODE_NORMAL);                 // [RL17]
  wire       go_rst  = wr_spe & c_inv & (sel == `SBC_SEL_RESET);
  wire       go_fl   = wr_spe & c_inv & (sel == `SBC_SEL_FLASH);
  wire       go_safe = wr_spe & c_safe & (sel == `SBC_SEL_INIT) & in_init;

  // header decode for the read answer
  wire [1:0] h_rw    = hdr_byte[7:6];
  wire [4:0] h_addr  = hdr_byte[5:1];
  wire       rd_hdr  = hdr_valid & (h_rw == `SBC_RW_READ);

  // ***********************************
  // registers, random code and read answer
  // ***********************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_pin_init_config    <= `SBC_IO_RESET;
      misc_init_config      <= `SBC_MISC_RESET;
      secured_mode_register <= `SBC_SPE_RESET;
      lfsr                  <= `SBC_LFSR_SEED;
      rnd_code              <= 6'h00;
      code_armed            <= 1'b0;
      tx_byte               <= 8'h00;
    end else if (clk_en) begin
      lfsr <= lfsr_next(lfsr);
      if (wr_io)
        io_pin_init_config <= f_data;
      if (wr_misc)
        misc_init_config <= f_data;
      // a secured write always consumes the code
      if (wr_spe) begin
        code_armed <= 1'b0;
        if (go_init | go_rst | go_fl | go_safe)
          secured_mode_register <= f_data;
      end
      if (hdr_valid) begin
        tx_byte <= 8'h00;
        if (rd_hdr && h_addr == `SBC_ADDR_SPE) begin
          rnd_code   <= lfsr;                                 // [RL16]
          code_armed <= 1'b1;
          tx_byte    <= {2'h0, lfsr};                         // [RL16]
        end else if (rd_hdr && h_addr == `SBC_ADDR_IO) begin
          tx_byte <= io_pin_init_config;
        end else if (rd_hdr && h_addr == `SBC_ADDR_MISC) begin
          tx_byte <= misc_init_config;
        end
      end
    end
  end

  // ***********************************
  // device mode state
  // ***********************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dev_mode <= `SBC_MODE_INIT;
      safe_n   <= 1'b1;
    end else if (clk_en) begin
      if (go_safe)
        safe_n <= 1'b0;                                       // [RL18]
      if (go_rst) begin
        dev_mode <= `SBC_MODE_RESET;                          // [RL14]
      end else if (go_fl) begin
        dev_mode <= `SBC_MODE_FLASH;                          // [RL14]
      end else if (go_init) begin
        dev_mode <= `SBC_MODE_INIT;                           // [RL14]
      end else begin
        case (dev_mode)
          MD_RESET: begin
            if (mode_reset_done)
              dev_mode <= MD_INIT;
          end
          MD_INIT, MD_FLASH: begin
            if (mode_normal_req)
              dev_mode <= MD_NORMAL;
          end
          MD_NORMAL: begin
            dev_mode <= MD_NORMAL;
          end
          default: begin
            dev_mode <= MD_INIT;
          end
        endcase
      end
    end
  end

  // ***********************************
  // io pin drivers and cyclic sense
  // ***********************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lp_d       <= 1'b0;
      saved_hs   <= 1'b0;
      saved_ls   <= 1'b0;
      io1_drv_en <= 1'b0;
      io0_hs_on  <= 1'b0;
      io0_ls_on  <= 1'b0;
    end else if (clk_en) begin
      lp_d       <= lowpower;
      io1_drv_en <= io_pin_init_config[`SBC_IO1_OUT_EN];      // [RL1]
      // keep the driver state seen just before low power
      if (lowpower && !lp_d) begin
        saved_hs <= io0_hs_on;
        saved_ls <= io0_ls_on;
      end
      if (!lowpower || !lp_d) begin
        io0_hs_on <= io0_hs_req & io_pin_init_config[`SBC_IO0_OUT_EN];  // [RL2]
        io0_ls_on <= io0_ls_req & io_pin_init_config[`SBC_IO0_OUT_EN];  // [RL2]
      end else if (cyc_active) begin
        io0_hs_on <= saved_hs;                                // [RL3]
        io0_ls_on <= saved_ls;                                // [RL3]
      end else if (io_pin_init_config[`SBC_IO_CYC_INV]) begin
        io0_hs_on <= saved_ls;                                // [RL4]
        io0_ls_on <= saved_hs;                                // [RL4]
      end else begin
        io0_hs_on <= 1'b0;                                    // [RL3]
        io0_ls_on <= 1'b0;                                    // [RL3]
      end
    end
  end

  // ***********************************
  // interrupt pin
  // ***********************************
  wire        int_fire = int_event | (wd_half_period &
                         misc_init_config[`SBC_MISC_INT_FLSH] &
                         (dev_mode == `SBC_MODE_FLASH));      // [RL10]
  wire [14:0] int_len  = misc_init_config[`SBC_MISC_INT_WID] ?
                         INT_SHORT_CYC : INT_LONG_CYC;        // [RL9]

  // pulse counter or held level, a new event wins over a clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt <= 15'h0000;
      int_n   <= 1'b1;
    end else if (clk_en) begin
      if (misc_init_config[`SBC_MISC_INT_LVL]) begin
        int_cnt <= 15'h0000;
        if (int_fire)
          int_n <= 1'b0;                                      // [RL8]
        else if (int_clear)
          int_n <= 1'b1;
      end else if (int_fire) begin
        int_cnt <= int_len - 15'h0001;                        // [RL9]
        int_n   <= 1'b0;                                      // [RL8]
      end else if (int_cnt != 15'h0000) begin
        int_cnt <= int_cnt - 15'h0001;
      end else begin
        int_n <= 1'b1;
      end
    end
  end

  // ***********************************
  // low power entry flag and debug resistor
  // ***********************************
  wire dbg_on = misc_init_config[`SBC_MISC_DBG_TOP];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dbg_m                 <= 2'h0;
      dbg_q                 <= 2'h0;
      dbg_mismatch          <= 1'b0;
      safe_override         <= 1'b0;
      safe_mode_sel         <= 2'h0;
      lowpower_random_entry <= 1'b0;
    end else if (clk_en) begin
      dbg_m <= dbg_hw_code;
      dbg_q <= dbg_m;
      lowpower_random_entry <= misc_init_config[`SBC_MISC_LP_RND];  // [RL6]
      safe_override <= dbg_on;                                // [RL11]
      safe_mode_sel <= dbg_on ? misc_init_config[1:0] : dbg_q; // [RL13]
      if (dbg_on && (dbg_q != misc_init_config[1:0]))
        dbg_mismatch <= 1'b1;                                 // [RL12]
      else if (dbg_flag_clear)
        dbg_mismatch <= 1'b0;
    end
  end

endmodule // sbc_init_mode_config

// *** sbc_spi_mst.sv ***
// spi master model that sends the configuration frames
module sbc_spi_mst (
  input  wire logic clk_sys,
  input  wire logic spi_miso,
  output logic      spi_sclk,
  output logic      spi_mosi,
  output logic      spi_cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 8;

  // idle bus: clock low, frame closed
  initial begin
    spi_sclk = 1'b0;
    spi_mosi = 1'b1;
    spi_cs_n = 1'b1;
  end

  // one 16 bit frame msb first, answer byte taken on rising sclk
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    @(negedge clk_sys);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = w[i];
      repeat (half) @(negedge clk_sys);
      spi_sclk = 1'b1;
      if (i < 8) rd[i] = spi_miso;
      repeat (half) @(negedge clk_sys);
      spi_sclk = 1'b0;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~w[0]; // released line shows no stale value
    repeat (half) @(negedge clk_sys);
  endtask
endmodule // sbc_spi_mst

// *** sbc_init_mode_config_props.sv ***
// port assertions of the configuration block
`include "sbc_defines.vh"
module sbc_imc_props #(
  parameter [14:0] INT_LONG_CYC  = `SBC_INT_LONG_CYC,
  parameter [14:0] INT_SHORT_CYC = `SBC_INT_SHORT_CYC
) (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       clk_en,
  input wire       mode_reset_done,
  input wire       mode_normal_req,
  input wire       lowpower,
  input wire       cyc_active,
  input wire       io0_hs_req,
  input wire       int_event,
  input wire       int_clear,
  input wire       wd_half_period,
  input wire [1:0] dbg_hw_code,
  input wire       dbg_flag_clear,
  input wire [1:0] dev_mode,
  input wire       io1_drv_en,
  input wire       io0_hs_on,
  input wire       io0_ls_on,
  input wire       int_n,
  input wire       safe_n,
  input wire       dbg_mismatch,
  input wire       safe_override,
  input wire [1:0] safe_mode_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  int low_cnt;

  // cycles the interrupt pin has been low
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) low_cnt <= 0;
    else if (int_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end

  // ****
  // low power and debug sequences
  // ****
  sequence s_lp_act;
    (lowpower && cyc_active && clk_en)[*3];
  endsequence
  sequence s_dbg_bad;
    (safe_override && clk_en && $stable(dbg_hw_code) && safe_mode_sel != dbg_hw_code)[*5];
  endsequence

  a_safe_pin_sticky: assert property (!safe_n |=> !safe_n)
    else $error("safe pin released");
  a_int_has_cause: assert property ($fell(int_n) |-> $past(int_event || wd_half_period))
    else $error("interrupt without cause");
  a_int_min_width: assert property ($rose(int_n) |-> $past(int_clear) || low_cnt >= INT_SHORT_CYC)
    else $error("interrupt pulse too short");
  a_reset_to_init: assert property (mode_reset_done && clk_en &&
    dev_mode == `SBC_MODE_RESET |=> dev_mode == `SBC_MODE_INIT) else $error("no init after reset");
  a_io0_req_gate: assert property (!lowpower && clk_en && !io0_hs_req |=> !io0_hs_on)
    else $error("high side on without request");
  a_cyc_active_hold: assert property (s_lp_act |=> $stable({io0_hs_on, io0_ls_on}))
    else $error("io0 moved in active time");
  a_cyc_off_swap: assert property (s_lp_act ##1 (lowpower && !cyc_active && clk_en) |=>
    (io0_hs_on == $past(io0_ls_on) && io0_ls_on == $past(io0_hs_on)) || !(io0_hs_on || io0_ls_on))
    else $error("io0 off time wrong");
  a_dbg_flag_sticky: assert property (dbg_mismatch && !dbg_flag_clear |=> dbg_mismatch)
    else $error("debug flag lost");
  a_dbg_flag_set: assert property (s_dbg_bad |=> dbg_mismatch)
    else $error("debug flag not set");
  a_hw_code_follow: assert property ((!safe_override && clk_en && $stable(dbg_hw_code))[*6]
    |-> safe_mode_sel == dbg_hw_code) else $error("safe mode not from pin");
  a_io1_init_only: assert property ($changed(io1_drv_en) |->
    $past(dev_mode, 2) == `SBC_MODE_INIT) else $error("io1 changed outside init");
endmodule // sbc_imc_props

bind sbc_init_mode_config sbc_imc_props #(.INT_LONG_CYC(INT_LONG_CYC),
  .INT_SHORT_CYC(INT_SHORT_CYC)) chk_u (.*);

// *** tb_sbc_init_mode_config.sv ***
// self-checking bench of the configuration block
`include "sbc_defines.vh"
module tb_sbc_init_mode_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys, rst_n, clk_en, spi_sclk, spi_mosi, spi_cs_n, spi_miso;
  logic       mode_reset_done, mode_normal_req, lowpower, cyc_active, io0_hs_req;
  logic       io0_ls_req, int_event, int_clear, wd_half_period, dbg_flag_clear;
  logic [1:0] dbg_hw_code, dev_mode, safe_mode_sel;
  logic       io1_drv_en, io0_hs_on, io0_ls_on, lowpower_random_entry, int_n;
  logic       safe_n, dbg_mismatch, safe_override, par_on;
  logic [7:0] rd, code, n;
  int         fails, num_checks;

  sbc_init_mode_config #(.INT_LONG_CYC(15'h0014), .INT_SHORT_CYC(15'h0005)) dut_u (.*);
  sbc_spi_mst mst_u (.*);

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ****
  // tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [15:0] w, output logic [7:0] r);
    if (par_on) w[8] = ^{w[15:9], w[7:0]};
    mst_u.xfer(w, r);
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic wt(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  // kind 0 inverted code, 1 safe code, else plain code
  task automatic secure(input logic [1:0] sel, input int kind);
    frame(16'h1300, code);
    if (kind == 0) code = {sel, ~code[5:0]};
    else if (kind == 1) code = {sel, code[5:4], ~code[3:0]};
    else code = {sel, code[5:0]};
    frame({8'h52, code}, rd);
  endtask

  task automatic int_width(output logic [7:0] k);
    pulse(int_event);
    k = 8'h00;
    while (int_n === 1'b1 && k < 8'h32) begin
      @(negedge clk_sys);
      k++;
    end
    k = 8'h00;
    while (int_n === 1'b0 && k < 8'h64) begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end

  // ****
  // tests
  // ****
  initial begin
    {mode_reset_done, mode_normal_req, lowpower, cyc_active, io0_hs_req} = 5'h00;
    {io0_ls_req, int_event, int_clear, wd_half_period, dbg_flag_clear} = 5'h00;
    dbg_hw_code = 2'h3;
    clk_en = 1'b1;
    rst_n = 1'b0;
    par_on = 1'b0;
    wt(20);
    rst_n = 1'b1;
    wt(4);
    chk({dev_mode, safe_n, int_n, io1_drv_en, dbg_mismatch}, {`SBC_MODE_INIT, 4'hC});
    $display("test reset done");
    io0_hs_req = 1'b1;
    frame(16'h4E06, rd);
    chk({io1_drv_en, io0_hs_on, io0_ls_on}, 3'h6);
    frame(16'h0E00, rd);
    chk(rd, 8'h06);
    io0_ls_req = 1'b1;
    wt(2);
    chk({io0_hs_on, io0_ls_on}, 2'h3);
    io0_ls_req = 1'b0;
    $display("test io done");
    frame(16'h5087, rd);
    chk({lowpower_random_entry, safe_override, safe_mode_sel}, 4'hF);
    for (int c = 0; c < 4; c++) begin
      frame(16'h5084 + c[15:0], rd);
      chk({safe_override, safe_mode_sel}, 3'h4 + c[2:0]);
    end
    pulse(dbg_flag_clear);
    wt(2);
    chk(dbg_mismatch, 1'b0);
    dbg_hw_code = 2'h1;
    wt(8);
    pulse(dbg_flag_clear);
    wt(2);
    chk(dbg_mismatch, 1'b1);
    dbg_hw_code = 2'h3;
    wt(8);
    pulse(dbg_flag_clear);
    frame(16'h5003, rd);
    dbg_hw_code = 2'h2;
    wt(8);
    chk({lowpower_random_entry, dbg_mismatch, safe_override, safe_mode_sel}, 5'h02);
    $display("test debug done");
    mst_u.xfer(16'h5147, rd);
    frame(16'h1000, rd);
    chk(rd, 8'h03);
    frame(16'h5047, rd);
    par_on = 1'b1;
    mst_u.xfer(16'h5040, rd);
    frame(16'h1000, rd);
    chk(rd, 8'h47);
    frame(16'h5018, rd);
    par_on = 1'b0;
    frame(16'h1000, rd);
    chk(rd, 8'h18);
    $display("test parity done");
    int_width(n);
    chk(n, 8'h05);
    frame(16'h5008, rd);
    int_width(n);
    chk(n, 8'h14);
    frame(16'h5028, rd);
    pulse(int_event);
    wt(30);
    chk(int_n, 1'b0);
    pulse(int_clear);
    pulse(wd_half_period);
    wt(2);
    chk(int_n, 1'b1);
    $display("test interrupt done");
    for (int v = 0; v < 2; v++) begin
      frame(16'h4E02 + v[15:0], rd);
      lowpower = 1'b1;
      cyc_active = 1'b1;
      wt(4);
      chk({io1_drv_en, io0_hs_on, io0_ls_on}, 3'h2);
      cyc_active = 1'b0;
      wt(2);
      chk({io0_hs_on, io0_ls_on}, {1'b0, v[0]});
      lowpower = 1'b0;
    end
    frame(16'h4E00, rd);
    chk({io0_hs_on, io0_ls_on}, 2'h0);
    $display("test low power done");
    clk_en = 1'b0;
    pulse(mode_normal_req);
    wt(3);
    chk(dev_mode, `SBC_MODE_INIT);
    clk_en = 1'b1;
    secure(`SBC_SEL_INIT, 0);
    chk(dev_mode, `SBC_MODE_INIT);
    pulse(mode_normal_req);
    wt(1);
    chk(dev_mode, `SBC_MODE_NORMAL);
    frame(16'h5080, rd);
    frame(16'h1000, rd);
    chk(rd, 8'h28);
    secure(`SBC_SEL_INIT, 2);
    chk(dev_mode, `SBC_MODE_NORMAL);
    secure(`SBC_SEL_INIT, 0);
    chk(dev_mode, `SBC_MODE_INIT);
    secure(`SBC_SEL_INIT, 1);
    chk({dev_mode, safe_n}, {`SBC_MODE_INIT, 1'b0});
    secure(2'h3, 0);
    chk(dev_mode, `SBC_MODE_INIT);
    secure(`SBC_SEL_FLASH, 0);
    chk(dev_mode, `SBC_MODE_FLASH);
    pulse(wd_half_period);
    wt(1);
    chk(int_n, 1'b0);
    pulse(int_clear);
    secure(`SBC_SEL_RESET, 0);
    chk(dev_mode, `SBC_MODE_RESET);
    pulse(mode_reset_done);
    wt(1);
    chk({dev_mode, safe_n}, {`SBC_MODE_INIT, 1'b0});
    $display("test secured done");
    print_verdict();
  end
endmodule // tb_sbc_init_mode_config
